/* eeprom_pkg.sv */
// Constants, types and timing shared by the two-wire EEPROM engine.
// Assumes a 125 MHz ref_clk that samples every pin.
// Function
// - Device address 1010, don't cares, read bit.
// - Acknowledge each received byte on ninth clock.
// - Mismatched address: no acknowledge, back to idle.
// - Byte write: device, word address, data, stop.
// - Stop after write starts self-timed, deaf programming.
// - Write cycle timed from stop to program end.
// - Started programming completes despite aux pin low.
// - Page write takes up to eight acknowledged bytes.
// - Write address wraps within low three bits.
// - Address unacknowledged until programming has finished.
// - Aux clock pin low makes array read-only.
// - Low supply detector inhibits all programming.
// - Read starts like write with direction one.
// - Address counter keeps last address plus one.
// - Read address wraps over whole array.
// - Current read: acknowledge, send byte at counter.
// - Sequential read continues while controller acknowledges.
package eeprom_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DEPTH_BYTES = 128;
  localparam int unsigned PAGE_BYTES = 8;
  localparam int unsigned PAGE_IDX_W = 3;
  localparam int unsigned BYTE_BITS = 8;

  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int unsigned DEV_TYPE_MSB = 7;
  localparam int unsigned DEV_TYPE_LSB = 4;
  localparam int unsigned DEV_RW_BIT = 0;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WRITE_CYCLE_TIME_NS = 5000;
  localparam int unsigned WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 24;

  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W = ADDR_W + BYTE_BITS;

  localparam logic [3:0] BIT_COUNT_LAST = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RX     = 5'b00010,
    ST_RX_ACK = 5'b00100,
    ST_TX     = 5'b01000,
    ST_TX_ACK = 5'b10000
  } state_t;

  typedef enum logic [1:0] {
    KIND_DEV  = 2'h0,
    KIND_WADR = 2'h1,
    KIND_DATA = 2'h2
  } kind_t;

endpackage

/* byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 4
) (
  input wire logic ref_clk,              // Clock
  input wire logic rst_n,                // Asynchronous reset, active low
  input wire logic flush,                // Empties the FIFO
  input wire logic in_valid,             // Write side offers a word
  output logic in_ready,                 // FIFO has room
  input wire logic [WIDTH-1:0] in_data,  // Word written
  output logic out_valid,                // FIFO holds a word
  input wire logic out_ready,            // Read side takes the word
  output logic [WIDTH-1:0] out_data      // Oldest word
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_t;

  fifo_t s_q;
  fifo_t s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.cnt != PW'(0) + (PW+1)'(DEPTH)) && !flush;
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wp] = in_data;
        s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : s_q.wp + PW'(1);
      end
      if (pop) begin
        s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : s_q.rp + PW'(1);
      end
      s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* eeprom_engine.sv */
// Two-wire target engine of a 128-byte EEPROM in bidirectional mode.
// Assumes scl, sda, aux clock pin and low-supply flag are asynchronous pins;
// the sda pad is open drain and resolved outside from sda_oe.
`timescale 1ns/1ps
module eeprom_engine
  import eeprom_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WRITE_CYCLE_CYCLES
) (
  input wire logic ref_clk,        // 125 MHz clock
  input wire logic rst_n,          // Asynchronous reset, active low
  input wire logic scl_in,         // Serial clock pin
  input wire logic sda_in,         // Serial data pin level
  output logic sda_out,            // Serial data drive value, always low
  output logic sda_oe,             // High while pulling sda low
  input wire logic aux_clock_pin,  // High enables writes
  input wire logic low_supply,     // High while supply is below threshold
  output logic write_busy          // High during the self-timed write
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] aux_s;
    logic [1:0] low_s;
    logic scl_d1;
    logic sda_d1;
    state_t st;
    kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic oe;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] pf;
    logic [ADDR_W-PAGE_IDX_W-1:0] page;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] mask;
    logic pend;
    logic wen;
    logic busy;
    logic [TIMER_W-1:0] timer;
    logic [PAGE_IDX_W:0] cidx;
    logic drv;
  } eng_t;

  eng_t s_q;
  eng_t s_d;

  logic [7:0] mem [DEPTH_BYTES];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;

  logic fifo_flush;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [FIFO_W-1:0] fifo_out;
  logic [FIFO_W-1:0] fifo_in;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
    page_next = {a[ADDR_W-1:PAGE_IDX_W], a[PAGE_IDX_W-1:0] + PAGE_IDX_W'(1)};
  endfunction

  function automatic logic [ADDR_W-1:0] array_next(input logic [ADDR_W-1:0] a);
    array_next = a + ADDR_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // Bus conditions from synchronised pins
  // ----------------------------------------------------------------
  // Both lines pass the same flop depth, so a data change just before a clock
  // edge is never seen after it and cannot fake a start or a stop
  assign scl_rise = s_q.scl_s[1] && !s_q.scl_d1;
  assign scl_fall = !s_q.scl_s[1] && s_q.scl_d1;
  assign start_c = s_q.scl_s[1] && s_q.scl_d1 && s_q.sda_d1 && !s_q.sda_s[1];
  assign stop_c = s_q.scl_s[1] && s_q.scl_d1 && !s_q.sda_d1 && s_q.sda_s[1];

  // ----------------------------------------------------------------
  // Read prefetch into the FIFO
  // ----------------------------------------------------------------
  // Keeps the next read bytes ready so the first data bit can be driven
  // a few clocks after the ack clock falls; a start or a new word address
  // flushes it, and nothing is fetched while the array is being written
  assign fifo_in = {s_q.pf, mem[s_q.pf]};
  assign fifo_in_valid = !s_q.busy;

  byte_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    fifo_flush = 1'b0;
    fifo_pop = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;

    s_d.scl_s = {s_q.scl_s[0], scl_in};
    s_d.sda_s = {s_q.sda_s[0], sda_in};
    s_d.aux_s = {s_q.aux_s[0], aux_clock_pin};
    s_d.low_s = {s_q.low_s[0], low_supply};
    s_d.scl_d1 = s_q.scl_s[1];
    s_d.sda_d1 = s_q.sda_s[1];

    // Prefetch runs ahead of the read pointer while there is room
    if (fifo_in_valid && fifo_in_ready) begin
      s_d.pf = array_next(s_q.pf);
    end

    // Any low seen on the aux pin during a write sequence blocks it
    if (!s_q.aux_s[1]) begin
      s_d.wen = 1'b0;
    end

    if (s_q.busy) begin
      // Self-timed write: bus is ignored, aux pin no longer looked at
      // Only cells received in this frame are written, one per clock;
      // the timer alone decides when polling is answered again
      s_d.st = ST_IDLE;
      s_d.oe = 1'b0;
      if (s_q.cidx < (PAGE_IDX_W+1)'(PAGE_BYTES)) begin
        if (s_q.mask[s_q.cidx[PAGE_IDX_W-1:0]] && !s_q.low_s[1]) begin
          mem_we = 1'b1;
          mem_wa = {s_q.page, s_q.cidx[PAGE_IDX_W-1:0]};
          mem_wd = s_q.pbuf[s_q.cidx[PAGE_IDX_W-1:0]];
        end
        s_d.cidx = s_q.cidx + (PAGE_IDX_W+1)'(1);
      end
      if (s_q.timer == TIMER_W'(1)) begin
        s_d.busy = 1'b0;
        s_d.pend = 1'b0;
        s_d.mask = '0;
      end
      s_d.timer = s_q.timer - TIMER_W'(1);
    end else if (stop_c) begin
      // Programming starts only if data arrived, the aux pin stayed high
      // from start to stop and the supply is good; otherwise drop the page
      s_d.st = ST_IDLE;
      s_d.oe = 1'b0;
      if (s_q.pend && s_q.wen && !s_q.low_s[1]) begin
        s_d.busy = 1'b1;
        s_d.timer = TIMER_W'(WR_CYCLES);
        s_d.cidx = '0;
      end else begin
        s_d.pend = 1'b0;
        s_d.mask = '0;
      end
    end else if (start_c) begin
      // Each start re-arms the write enable from the aux pin and restarts
      // the prefetch at the address counter
      s_d.st = ST_RX;
      s_d.kind = KIND_DEV;
      s_d.cnt = '0;
      s_d.oe = 1'b0;
      s_d.wen = s_q.aux_s[1];
      s_d.pend = 1'b0;
      s_d.mask = '0;
      fifo_flush = 1'b1;
      s_d.pf = s_q.addr;
    end else begin
      case (s_q.st)
        ST_RX: begin
          if (scl_rise) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (scl_fall && s_q.cnt == BIT_COUNT_LAST) begin
            s_d.st = ST_RX_ACK;
            s_d.oe = 1'b1;
            if (s_q.kind == KIND_DEV) begin
              s_d.rw = s_q.sh[DEV_RW_BIT];
              if (s_q.sh[DEV_TYPE_MSB:DEV_TYPE_LSB] != DEV_TYPE_CODE) begin
                s_d.st = ST_IDLE;
                s_d.oe = 1'b0;
              end
            end else if (s_q.kind == KIND_WADR) begin
              s_d.addr = s_q.sh[ADDR_W-1:0];
              s_d.page = s_q.sh[ADDR_W-1:PAGE_IDX_W];
              fifo_flush = 1'b1;
              s_d.pf = s_q.sh[ADDR_W-1:0];
            end else begin
              s_d.pbuf[s_q.addr[PAGE_IDX_W-1:0]] = s_q.sh;
              s_d.mask[s_q.addr[PAGE_IDX_W-1:0]] = 1'b1;
              s_d.pend = 1'b1;
              s_d.addr = page_next(s_q.addr);
            end
          end
        end
        ST_RX_ACK: begin
          // Ack release and the first read bit share this falling edge
          if (scl_fall) begin
            s_d.oe = 1'b0;
            s_d.cnt = '0;
            if (s_q.kind == KIND_DEV && s_q.rw) begin
              s_d.st = ST_TX;
              fifo_pop = fifo_out_valid;
              s_d.sh = fifo_out_valid ? fifo_out[7:0] : IDLE_BYTE;
              s_d.oe = fifo_out_valid ? !fifo_out[7] : 1'b0;
              if (fifo_out_valid) begin
                s_d.addr = array_next(fifo_out[FIFO_W-1:8]);
              end
              s_d.cnt = 4'h1;
            end else begin
              s_d.st = ST_RX;
              s_d.kind = (s_q.kind == KIND_DEV) ? KIND_WADR : KIND_DATA;
            end
          end
        end
        ST_TX: begin
          // Bit 7 already stands; shift out seven more, then free the line
          if (scl_fall) begin
            if (s_q.cnt == BIT_COUNT_LAST) begin
              s_d.oe = 1'b0;
              s_d.st = ST_TX_ACK;
            end else begin
              s_d.sh = {s_q.sh[6:0], 1'b1};
              s_d.oe = !s_q.sh[6];
              s_d.cnt = s_q.cnt + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            s_d.mack = !s_q.sda_s[1];
          end else if (scl_fall) begin
            if (s_q.mack) begin
              s_d.st = ST_TX;
              fifo_pop = fifo_out_valid;
              s_d.sh = fifo_out_valid ? fifo_out[7:0] : IDLE_BYTE;
              s_d.oe = fifo_out_valid ? !fifo_out[7] : 1'b0;
              if (fifo_out_valid) begin
                s_d.addr = array_next(fifo_out[FIFO_W-1:8]);
              end
              s_d.cnt = 4'h1;
            end else begin
              s_d.st = ST_IDLE;
            end
          end
        end
        default: begin
          s_d.st = ST_IDLE;
          s_d.oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pin history resets to the idle-high bus so no false start follows reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.scl_s <= 2'h3;
      s_q.sda_s <= 2'h3;
      s_q.scl_d1 <= 1'b1;
      s_q.sda_d1 <= 1'b1;
      s_q.st <= ST_IDLE;
      s_q.kind <= KIND_DEV;
    end else begin
      s_q <= s_d;
    end
  end

  // Array contents persist; no reset on the cells
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_out = s_q.drv;
  assign sda_oe = s_q.oe;
  assign write_busy = s_q.busy;

endmodule

/* eeprom_checker.sv */
// Pin-level assertions for the two-wire EEPROM engine.
// Assumes only the engine's ports; bound to it at the foot.
`timescale 1ns/1ps
module eeprom_checker #(
  parameter int unsigned WR_CYCLES = 625
) (
  input wire logic ref_clk,        // Clock
  input wire logic rst_n,          // Reset, active low
  input wire logic scl_in,         // Serial clock
  input wire logic sda_in,         // Data wire level
  input wire logic sda_out,        // Drive value
  input wire logic sda_oe,         // Data pull enable
  input wire logic aux_clock_pin,  // Write enable pin
  input wire logic low_supply,     // Low supply flag
  input wire logic write_busy      // Self-timed write
);
  logic sda_q;
  logic prot_q;
  logic lowv_q;
  logic [15:0] busy_cnt_q;
  logic [3:0] stop_age_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Bus event tracking: stop age, busy length, aux and supply lows since the last start
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= 1'b1;
      prot_q <= 1'b0;
      lowv_q <= 1'b0;
      busy_cnt_q <= 16'h0;
      stop_age_q <= 4'hf;
    end else begin
      sda_q <= sda_in;
      busy_cnt_q <= write_busy ? busy_cnt_q + 16'h1 : 16'h0;
      if (scl_in && sda_in && !sda_q)
        stop_age_q <= 4'h0;
      else if (stop_age_q != 4'hf)
        stop_age_q <= stop_age_q + 4'h1;
      if (scl_in && !sda_in && sda_q) begin
        prot_q <= !aux_clock_pin;
        lowv_q <= low_supply;
      end else begin
        prot_q <= prot_q | !aux_clock_pin;
        lowv_q <= lowv_q | low_supply;
      end
    end
  end
  sequence busy_run;
    write_busy [*8];
  endsequence
  busy_len_a: assert property ($fell(write_busy) |-> busy_cnt_q == WR_CYCLES)
    else $error("write cycle length wrong");
  busy_hold_a: assert property ($rose(write_busy) |-> busy_run)
    else $error("write cycle cut short");
  busy_deaf_a: assert property (write_busy |-> !sda_oe)
    else $error("answer given while programming");
  busy_stop_a: assert property ($rose(write_busy) |-> stop_age_q <= 4'ha)
    else $error("write cycle not started by stop");
  prot_block_a: assert property ($rose(write_busy) |-> !prot_q)
    else $error("write while aux pin low");
  lowv_block_a: assert property ($rose(write_busy) |-> !lowv_q)
    else $error("write while supply low");
  ack_release_a: assert property ($rose(sda_oe) |-> ##[1:150] !sda_oe)
    else $error("data line held too long");
  oe_low_phase_a: assert property ($rose(sda_oe) |-> !$past(scl_in))
    else $error("data pulled while clock high");
  drive_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data pad driven high");
endmodule

bind eeprom_engine eeprom_checker #(.WR_CYCLES(WR_CYCLES)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .aux_clock_pin(aux_clock_pin), .low_supply(low_supply), .write_busy(write_busy));

/* bus_ctrl_model.sv */
// Two-wire bus controller model with a 64 ns serial clock.
// Assumes an open-drain data wire with pull-up resolved by the bench.
`timescale 1ns/1ps
module bus_ctrl_model
  import eeprom_pkg::*;
(
  input wire logic ref_clk,  // Bench clock
  input wire logic sda,      // Resolved data wire
  output logic scl,          // Serial clock, high when idle
  output logic sda_low       // High while pulling data low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ----------------------------------------
  // Bit and frame level tasks
  // ----------------------------------------
  task automatic q(input int n = 1);
    repeat (2 * n) @(posedge ref_clk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q(2);
    sda_low <= 1'b1;
    q(2);
    scl <= 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q(2);
    sda_low <= 1'b0;
    q(2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
  endtask
  // Extra low time after the ninth bit lets the target release the line
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ack_in, ack);
    q(2);
  endtask
  task automatic dev(input logic rd, output logic ack);
    logic [7:0] r;
    start();
    xfer({DEV_TYPE_CODE, 3'h5, rd}, 1'b1, r, ack);
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the EEPROM engine against a memory model.
// Assumes the controller model and the checker bound to the engine.
`timescale 1ns/1ps
module testbench;
  import eeprom_pkg::*;
  localparam int unsigned WR_N = 200;
  logic ref_clk, rst_n, aux_clock_pin, low_supply;
  logic scl, ctl_low, sda_oe, sda_out, write_busy, ack;
  logic [7:0] r, a;
  wire logic sda;
  int mismatches, compares, cnt, n;
  int mem[128];
  logic [31:0] seed;
  assign sda = ~(ctl_low | (sda_oe & ~sda_out));
  eeprom_engine #(.WR_CYCLES(WR_N)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .aux_clock_pin(aux_clock_pin), .low_supply(low_supply),
    .write_busy(write_busy));
  bus_ctrl_model u_ctl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(ctl_low));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_idle();
    int i = 0;
    while (write_busy !== 1'b0) begin
      @(posedge ref_clk);
      i++;
      if (i > 4 * WR_N) begin
        mismatches++;
        stop_test();
      end
    end
  endtask
  task automatic wr(input logic [7:0] wa, input int wn, input logic prog, input logic drop);
    logic [7:0] d;
    logic k;
    int p;
    u_ctl.dev(1'b0, k);
    chk({7'h0, k}, 8'h0);
    u_ctl.xfer(wa, 1'b1, d, k);
    chk({7'h0, k}, 8'h0);
    for (int i = 0; i < wn; i++) begin
      d = 8'(rnd());
      u_ctl.xfer(d, 1'b1, r, k);
      chk({7'h0, k}, 8'h0);
      p = {wa[6:3], 3'(wa[2:0] + i)};
      if (prog)
        mem[p] = d;
    end
    u_ctl.stop();
    repeat (8) @(posedge ref_clk);
    chk({7'h0, write_busy}, {7'h0, prog});
    if (drop)
      aux_clock_pin <= 1'b0;
    if (prog) begin
      u_ctl.dev(1'b0, k);
      chk({7'h0, k}, 8'h1);
      u_ctl.stop();
    end
    wait_idle();
    aux_clock_pin <= 1'b1;
    cnt = {wa[6:3], 3'(wa[2:0] + wn)};
  endtask
  task automatic rd(input logic rand_a, input logic [7:0] ra, input int rn);
    logic k;
    if (rand_a) begin
      u_ctl.dev(1'b0, k);
      u_ctl.xfer(ra, 1'b1, r, k);
      chk({7'h0, k}, 8'h0);
      cnt = ra[6:0];
    end
    u_ctl.dev(1'b1, k);
    chk({7'h0, k}, 8'h0);
    for (int i = 0; i < rn; i++) begin
      u_ctl.xfer(8'hff, i == rn - 1, r, k);
      if (mem[cnt] >= 0)
        chk(r, 8'(mem[cnt]));
      cnt = (cnt + 1) % 128;
    end
    u_ctl.stop();
  endtask
  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    aux_clock_pin = 1'b1;
    low_supply = 1'b0;
    mismatches = 0;
    compares = 0;
    cnt = 0;
    seed = 32'd37692;
    foreach (mem[i])
      mem[i] = -1;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    u_ctl.start();
    u_ctl.xfer(8'h50, 1'b1, r, ack);
    chk({7'h0, ack}, 8'h1);
    u_ctl.xfer(8'ha0, 1'b1, r, ack);
    chk({7'h0, ack}, 8'h1);
    u_ctl.stop();
    $display("test bad_address done");
    wr(8'h7b, 8, 1'b1, 1'b0);
    wr(8'h85, 10, 1'b1, 1'b0);
    rd(1'b0, 8'h00, 1);
    rd(1'b1, 8'h7c, 11);
    rd(1'b0, 8'h00, 1);
    $display("test page_and_read done");
    aux_clock_pin <= 1'b0;
    wr(8'h00, 2, 1'b0, 1'b0);
    low_supply <= 1'b1;
    wr(8'h02, 2, 1'b0, 1'b0);
    low_supply <= 1'b0;
    rd(1'b1, 8'h00, 4);
    $display("test protect done");
    wr(8'h40, 1, 1'b1, 1'b1);
    rd(1'b1, 8'h40, 1);
    $display("test aux_drop done");
    for (int k = 0; k < 4; k++) begin
      a = 8'(rnd());
      n = 1 + int'(rnd() % 8);
      wr(a, n, 1'b1, 1'b0);
      rd(1'b1, a, n);
    end
    $display("test random done");
    stop_test();
  end
endmodule
